// ---- common/hrf_map.svh ----
`ifndef HRF_MAP_SVH
`define HRF_MAP_SVH
// ----------------------------------------------------------------
// register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define HRF_IDX_CMP1_LO    8'h40
`define HRF_IDX_MASK1_LO   8'h44
`define HRF_IDX_MASK1_HI   8'h45
`define HRF_IDX_MASK2_LO   8'h46
`define HRF_IDX_MASK2_HI   8'h47
`define HRF_IDX_LIMIT_LO   8'h48
`define HRF_IDX_LIMIT_HI   8'h49
`define HRF_IDX_EVT0       8'h50
`define HRF_IDX_EVT1       8'h51
`define HRF_IDX_EVT2       8'h52
`define HRF_IDX_EMASK0     8'h54
`define HRF_IDX_EMASK1     8'h55
`define HRF_IDX_EMASK2     8'h56
`define HRF_IDX_BCNT_LO    8'h5A
`define HRF_IDX_BCNT_HI    8'h5B
`define HRF_IDX_CONFIG     8'h5C
`define HRF_IDX_CHSTAT     8'h5D
// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define HRF_RST_BYTE       8'h00
`define HRF_RST_EMASK0     8'hFF
`define HRF_RST_EMASK1     8'hFF
`define HRF_RST_EMASK2     8'h03
`define HRF_RST_CONFIG     8'h61
// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define HRF_LIMIT_ENABLE   7
`define HRF_LIMIT_SHIFT    5
`define HRF_CFG_HDLC       0
`define HRF_CFG_AUTO       1
`define HRF_CFG_ADDR       2
`define HRF_CFG_TWO_BYTE   3
`define HRF_CFG_DMA        4
`define HRF_CFG_THR_LO     5
`define HRF_BCNT_OVF       4
`define HRF_EVT1_USED      8'hFE
`define HRF_EVT2_USED      8'h03
`endif

// ---- common/hrf_pkg.sv ----
package hrf_pkg;
	// receiver byte stream, one strobe per cycle
	typedef struct packed {
		logic       start;
		logic       byte_valid;
		logic [7:0] data;
		logic       frame_end;
		logic       line_abort;
		logic       crc_ok;
		logic       valid_frame;
	} hrf_rx_in_t;
	// automode frame checks from the protocol engine
	typedef struct packed {
		logic nr_error;
		logic s_with_info;
		logic rr_seen;
		logic rnr_seen;
	} hrf_auto_in_t;
	// link and transmit events collected here, one-cycle pulses
	typedef struct packed {
		logic [7:0] evt1;
		logic [1:0] evt2;
	} hrf_ext_ev_t;
	// write port into the receive fifo
	typedef struct packed {
		logic       valid;
		logic [7:0] data;
		logic       last;
	} hrf_fifo_wr_t;
	typedef enum logic [2:0] {
		ST_IDLE, ST_ADDR, ST_DATA, ST_STATUS, ST_DISCARD
	} hrf_state_t;
endpackage

// ---- core/hrf_rx_filter.sv ----
// How it works
// - mask bit one makes address bit match
// - mask bit zero needs exact address bit
// - length check off when enable bit zero
// - count every byte written into fifo
// - limit equals field plus one times 32
// - over-length frame ends like aborted frame
// - length event comes before message end
// - status byte counts toward frame length
// - lost bytes raise overflow, marked in status
// - dma mode marks overflow in count high
// - whole frame dropped raises fifo overflow
// - automode protocol errors raise protocol event
// - automode rr/rnr change raises status event
// - pool full when fill reaches threshold
// - message end when frame tail stored
// - low count bits follow threshold setting; here the threshold only sets pool full, count low reads cnt_r[7:0] whole
// - status byte written last every frame not discarded
// - frame start on address or flag
// - masked events never drive interrupt; reset masked
`include "hrf_map.svh"
`timescale 1ns/1ps
`default_nettype none
module hrf_rx_filter #(
	parameter int AW = 12
) (
	// clock and reset
	input  wire logic                 aclk,
	input  wire logic                 aresetn,
	// axi4-lite write channels
	input  wire logic                 awvalid,
	output logic                      awready,
	input  wire logic [AW-1:0]        awaddr,
	input  wire logic [2:0]           awprot,
	input  wire logic                 wvalid,
	output logic                      wready,
	input  wire logic [31:0]          wdata,
	input  wire logic [3:0]           wstrb,
	output logic                      bvalid,
	input  wire logic                 bready,
	output logic [1:0]                bresp,
	// axi4-lite read channels
	input  wire logic                 arvalid,
	output logic                      arready,
	input  wire logic [AW-1:0]        araddr,
	input  wire logic [2:0]           arprot,
	output logic                      rvalid,
	input  wire logic                 rready,
	output logic [31:0]               rdata,
	output logic [1:0]                rresp,
	// receiver and protocol engine
	input  wire hrf_pkg::hrf_rx_in_t  rx,
	input  wire hrf_pkg::hrf_auto_in_t auto_ev,
	input  wire hrf_pkg::hrf_ext_ev_t ext_ev,
	// receive fifo
	output var hrf_pkg::hrf_fifo_wr_t fifo_wr,
	input  wire logic                 fifo_full,
	// interrupt
	output logic                      irq
);
	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	function automatic logic byte_hit(input logic [7:0] rcv, input logic [7:0] cmp,
		input logic [7:0] msk);
		byte_hit = ((rcv ^ cmp) & ~msk) == 8'h00;
	endfunction
	function automatic logic addr_ok(input logic [AW-1:0] a);
		addr_ok = (a[1:0] == 2'h0) && ((a >> 10) == '0);
	endfunction
	function automatic logic [7:0] reg_idx(input logic [AW-1:0] a);
		reg_idx = a[9:2];
	endfunction

	// ------------------------------------------------------------
	// storage
	// ------------------------------------------------------------
	logic [7:0]          cmp_r [4];
	logic [7:0]          mask_r [4];
	logic [7:0]          lim_lo_r, lim_hi_r, cfg_r;
	logic [7:0]          evt_r [3];
	logic [7:0]          emask_r [3];
	hrf_pkg::hrf_state_t st_r, st_nxt;
	logic [16:0]         cnt_r;
	logic [7:0]          hi_r;
	logic                hi_seen_r, ovf_r, abort_r, crc_r, vfr_r, remote_r;
	logic [1:0]          ha_r;
	logic                aw_hold_r, w_hold_r, bvalid_r, rvalid_r, irq_r;
	logic [AW-1:0]       awaddr_r;
	logic [7:0]          wdata_r, rdata_r, rd_val;
	logic                wstb_r, rd_ok, rresp_err_r, wr_do;
	logic [7:0]          ev0;
	logic                ev_length_exceeded_event, ev_rfs, ev_rme, ev_rpf, ev_rdo, ev_rfo;
	logic                hit1, hit2, match, over, len_on;
	logic [16:0]         limit;
	logic [4:0]          thr_mask;
	logic [7:0]          status_byte, clr [3];

	// ------------------------------------------------------------
	// address filter and length limit
	// ------------------------------------------------------------
	// two-byte mode compares the saved high byte as well
	always_comb begin
		hit1 = byte_hit(rx.data, cmp_r[0], mask_r[0]);
		hit2 = byte_hit(rx.data, cmp_r[2], mask_r[2]);
		if (cfg_r[`HRF_CFG_TWO_BYTE]) begin
			hit1 = hit1 && byte_hit(hi_r, cmp_r[1], mask_r[1]);
			hit2 = hit2 && byte_hit(hi_r, cmp_r[3], mask_r[3]);
		end
		match = hit1 || hit2;
	end
	// limit in bytes is (field + 1) * 32, status byte included
	assign limit  = (17'({lim_hi_r[2:0], lim_lo_r}) + 17'h00001) << `HRF_LIMIT_SHIFT;
	assign len_on = lim_hi_r[`HRF_LIMIT_ENABLE] && cfg_r[`HRF_CFG_HDLC];
	assign over   = len_on && ((cnt_r + 17'h00002) > limit);
	assign status_byte = {vfr_r, ovf_r, crc_r, abort_r, ha_r, 2'h0};

	// threshold setting picks how many low count bits the pool full check tests
	always_comb begin
		unique case (cfg_r[`HRF_CFG_THR_LO +: 2])
			2'h0: thr_mask = 5'h01;
			2'h1: thr_mask = 5'h03;
			2'h2: thr_mask = 5'h0F;
			2'h3: thr_mask = 5'h1F;
		endcase
	end

	// ------------------------------------------------------------
	// frame sequencer
	// ------------------------------------------------------------
	// decides the next state, fifo writes and receive events
	always_comb begin
		st_nxt  = st_r;
		fifo_wr = '0;
		fifo_wr.data = rx.data;
		ev_length_exceeded_event = 1'b0;
		ev_rfs  = 1'b0;
		ev_rme  = 1'b0;
		ev_rdo  = 1'b0;
		ev_rfo  = 1'b0;
		unique case (st_r)
			hrf_pkg::ST_IDLE: begin
				if (rx.start) begin
					if (cfg_r[`HRF_CFG_ADDR]) begin
						st_nxt = hrf_pkg::ST_ADDR;
					end else begin
						st_nxt = hrf_pkg::ST_DATA;
						ev_rfs = 1'b1;
					end
				end
			end
			hrf_pkg::ST_ADDR: begin
				if (rx.line_abort || rx.frame_end) begin
					st_nxt = hrf_pkg::ST_IDLE;
				end else if (rx.byte_valid &&
					!(cfg_r[`HRF_CFG_TWO_BYTE] && !hi_seen_r)) begin
					if (match) begin
						st_nxt = hrf_pkg::ST_DATA;
						ev_rfs = 1'b1;
					end else begin
						st_nxt = hrf_pkg::ST_DISCARD;
					end
				end
			end
			hrf_pkg::ST_DATA: begin
				if (rx.line_abort || rx.frame_end) begin
					st_nxt = hrf_pkg::ST_STATUS;
				end else if (rx.byte_valid) begin
					if (over) begin
						ev_length_exceeded_event = 1'b1;
						st_nxt  = hrf_pkg::ST_STATUS;
					end else if (fifo_full) begin
						if (cnt_r == 17'h00000) begin
							ev_rfo = 1'b1;
							st_nxt = hrf_pkg::ST_DISCARD;
						end else begin
							ev_rdo = 1'b1;
						end
					end else begin
						fifo_wr.valid = 1'b1;
					end
				end
			end
			hrf_pkg::ST_STATUS: begin
				// status waits for room so it is never lost
				if (!fifo_full) begin
					fifo_wr.valid = 1'b1;
					fifo_wr.data  = status_byte;
					fifo_wr.last  = 1'b1;
					ev_rme        = 1'b1;
					st_nxt        = hrf_pkg::ST_IDLE;
				end
			end
			hrf_pkg::ST_DISCARD: begin
				if (rx.line_abort || rx.frame_end) begin
					st_nxt = hrf_pkg::ST_IDLE;
				end
			end
		endcase
	end

	// pool full on each data byte that completes a threshold block
	assign ev_rpf = fifo_wr.valid && !fifo_wr.last &&
		(((cnt_r[4:0] + 5'h01) & thr_mask) == 5'h00);

	// state register
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st_r <= hrf_pkg::ST_IDLE;
		end else begin
			st_r <= st_nxt;
		end
	end

	// byte count of the current frame, status byte included
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cnt_r <= 17'h00000;
		end else if (st_r == hrf_pkg::ST_IDLE && rx.start) begin
			cnt_r <= 17'h00000;
		end else if (fifo_wr.valid) begin
			cnt_r <= cnt_r + 17'h00001;
		end
	end

	// per-frame status flags and address capture
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			hi_r      <= 8'h00;
			hi_seen_r <= 1'b0;
			ha_r      <= 2'h0;
			ovf_r     <= 1'b0;
			abort_r   <= 1'b0;
			crc_r     <= 1'b0;
			vfr_r     <= 1'b0;
		end else if (st_r == hrf_pkg::ST_IDLE && rx.start) begin
			hi_seen_r <= 1'b0;
			ha_r      <= 2'h0;
			ovf_r     <= 1'b0;
			abort_r   <= 1'b0;
			crc_r     <= 1'b0;
			vfr_r     <= 1'b0;
		end else if (st_r == hrf_pkg::ST_ADDR && rx.byte_valid) begin
			hi_r      <= rx.data;
			hi_seen_r <= 1'b1;
			ha_r      <= {hit2, hit1};
		end else if (st_r == hrf_pkg::ST_DATA) begin
			if (ev_rdo) begin
				ovf_r <= 1'b1;
			end
			if (rx.line_abort || ev_length_exceeded_event) begin
				abort_r <= 1'b1;
			end else if (rx.frame_end) begin
				crc_r <= rx.crc_ok;
				vfr_r <= rx.valid_frame;
			end
		end
	end

	// remote receiver state from rr / rnr frames in automode
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			remote_r <= 1'b0;
		end else if (cfg_r[`HRF_CFG_AUTO] && auto_ev.rnr_seen) begin
			remote_r <= 1'b1;
		end else if (cfg_r[`HRF_CFG_AUTO] && auto_ev.rr_seen) begin
			remote_r <= 1'b0;
		end
	end

	// receive event vector in status register bit order
	assign ev0 = {ev_rdo, ev_rfo,
		cfg_r[`HRF_CFG_AUTO] && (auto_ev.nr_error || auto_ev.s_with_info),
		cfg_r[`HRF_CFG_AUTO] && ((auto_ev.rnr_seen && !remote_r) ||
			(auto_ev.rr_seen && !auto_ev.rnr_seen && remote_r)),
		ev_rpf, ev_rme, ev_rfs, ev_length_exceeded_event};

	// ------------------------------------------------------------
	// axi4-lite slave
	// ------------------------------------------------------------
	assign awready = !aw_hold_r && !bvalid_r;
	assign wready  = !w_hold_r && !bvalid_r;
	assign arready = !rvalid_r;
	assign wr_do   = aw_hold_r && w_hold_r;
	assign bvalid  = bvalid_r;
	assign bresp   = 2'h0;
	assign rvalid  = rvalid_r;
	assign rdata   = {24'h000000, rdata_r};
	assign rresp   = rresp_err_r ? 2'h2 : 2'h0;
	assign irq     = irq_r;

	// address and data are caught in either order, then applied
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_hold_r <= 1'b0;
			w_hold_r  <= 1'b0;
			bvalid_r  <= 1'b0;
			awaddr_r  <= '0;
			wdata_r   <= 8'h00;
			wstb_r    <= 1'b0;
		end else begin
			if (awvalid && awready) begin
				aw_hold_r <= 1'b1;
				awaddr_r  <= awaddr;
			end else if (wr_do) begin
				aw_hold_r <= 1'b0;
			end
			if (wvalid && wready) begin
				w_hold_r <= 1'b1;
				wdata_r  <= wdata[7:0];
				wstb_r   <= wstrb[0];
			end else if (wr_do) begin
				w_hold_r <= 1'b0;
			end
			if (wr_do) begin
				bvalid_r <= 1'b1;
			end else if (bready) begin
				bvalid_r <= 1'b0;
			end
		end
	end

	// software-written registers
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			for (int i = 0; i < 4; i++) begin
				cmp_r[i]  <= `HRF_RST_BYTE;
				mask_r[i] <= `HRF_RST_BYTE;
			end
			lim_lo_r   <= `HRF_RST_BYTE;
			lim_hi_r   <= `HRF_RST_BYTE;
			emask_r[0] <= `HRF_RST_EMASK0;
			emask_r[1] <= `HRF_RST_EMASK1;
			emask_r[2] <= `HRF_RST_EMASK2;
			cfg_r      <= `HRF_RST_CONFIG;
		end else if (wr_do && wstb_r && addr_ok(awaddr_r)) begin
			if ((reg_idx(awaddr_r) & 8'hFC) == `HRF_IDX_CMP1_LO) begin
				cmp_r[awaddr_r[3:2]] <= wdata_r;
			end
			if ((reg_idx(awaddr_r) & 8'hFC) == `HRF_IDX_MASK1_LO) begin
				mask_r[awaddr_r[3:2]] <= wdata_r;
			end
			if (reg_idx(awaddr_r) == `HRF_IDX_LIMIT_LO) lim_lo_r <= wdata_r;
			if (reg_idx(awaddr_r) == `HRF_IDX_LIMIT_HI) lim_hi_r <= wdata_r;
			if (reg_idx(awaddr_r) == `HRF_IDX_EMASK0) emask_r[0] <= wdata_r;
			if (reg_idx(awaddr_r) == `HRF_IDX_EMASK1) emask_r[1] <= wdata_r;
			if (reg_idx(awaddr_r) == `HRF_IDX_EMASK2) emask_r[2] <= wdata_r;
			if (reg_idx(awaddr_r) == `HRF_IDX_CONFIG) cfg_r <= wdata_r;
		end
	end

	// read multiplexer
	always_comb begin
		rd_val = 8'h00;
		rd_ok  = addr_ok(araddr);
		if ((reg_idx(araddr) & 8'hFC) == `HRF_IDX_CMP1_LO) begin
			rd_val = cmp_r[araddr[3:2]];
		end else if ((reg_idx(araddr) & 8'hFC) == `HRF_IDX_MASK1_LO) begin
			rd_val = mask_r[araddr[3:2]];
		end else begin
			case (reg_idx(araddr))
				`HRF_IDX_LIMIT_LO: rd_val = lim_lo_r;
				`HRF_IDX_LIMIT_HI: rd_val = lim_hi_r;
				`HRF_IDX_EVT0:     rd_val = evt_r[0];
				`HRF_IDX_EVT1:     rd_val = evt_r[1];
				`HRF_IDX_EVT2:     rd_val = evt_r[2];
				`HRF_IDX_EMASK0:   rd_val = emask_r[0];
				`HRF_IDX_EMASK1:   rd_val = emask_r[1];
				`HRF_IDX_EMASK2:   rd_val = emask_r[2];
				`HRF_IDX_BCNT_LO:  rd_val = cnt_r[7:0];
				`HRF_IDX_BCNT_HI:  rd_val = {3'h0,
					cfg_r[`HRF_CFG_DMA] && ovf_r, cnt_r[11:8]};
				`HRF_IDX_CONFIG:   rd_val = cfg_r;
				`HRF_IDX_CHSTAT:   rd_val = {7'h00, remote_r};
				default:           rd_ok  = 1'b0;
			endcase
		end
	end

	// read data is captured when the address is taken
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid_r    <= 1'b0;
			rdata_r     <= 8'h00;
			rresp_err_r <= 1'b0;
		end else if (arvalid && arready) begin
			rvalid_r    <= 1'b1;
			rdata_r     <= rd_ok ? rd_val : 8'h00;
			rresp_err_r <= !rd_ok;
		end else if (rready) begin
			rvalid_r <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// event status registers
	// ------------------------------------------------------------
	// a read clears only the bits it returned; a new event wins
	generate
		for (genvar g = 0; g < 3; g++) begin : g_evt
			assign clr[g] = (arvalid && arready && addr_ok(araddr) &&
				reg_idx(araddr) == (`HRF_IDX_EVT0 + 8'(g))) ? evt_r[g] : 8'h00;
		end
	endgenerate

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			evt_r[0] <= 8'h00;
			evt_r[1] <= 8'h00;
			evt_r[2] <= 8'h00;
		end else begin
			evt_r[0] <= (evt_r[0] & ~clr[0]) | ev0;
			evt_r[1] <= ((evt_r[1] & ~clr[1]) | ext_ev.evt1) & `HRF_EVT1_USED;
			evt_r[2] <= ((evt_r[2] & ~clr[2]) | {6'h00, ext_ev.evt2}) & `HRF_EVT2_USED;
		end
	end

	// interrupt line from unmasked pending events
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			irq_r <= 1'b0;
		end else begin
			irq_r <= |(evt_r[0] & ~emask_r[0]) | |(evt_r[1] & ~emask_r[1]) |
				|(evt_r[2] & ~emask_r[2]);
		end
	end

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	sequence s_over_byte;
		st_r == hrf_pkg::ST_DATA && !rx.line_abort && !rx.frame_end && rx.byte_valid && over;
	endsequence
	sequence s_abort_status;
		st_r == hrf_pkg::ST_STATUS && abort_r && !evt_r[0][2];
	endsequence

	AST_MASK_ACCEPT: assert property (
		st_r == hrf_pkg::ST_ADDR && !cfg_r[`HRF_CFG_TWO_BYTE] && rx.byte_valid &&
		!rx.line_abort && !rx.frame_end && mask_r[0] == 8'hFF |=> st_r == hrf_pkg::ST_DATA)
		else $error("fully masked address not accepted");
	AST_UNMASKED_REJECT: assert property (
		st_r == hrf_pkg::ST_ADDR && !cfg_r[`HRF_CFG_TWO_BYTE] && rx.byte_valid &&
		!rx.line_abort && !rx.frame_end &&
		(((rx.data ^ cmp_r[0]) & ~mask_r[0]) != 8'h00) &&
		(((rx.data ^ cmp_r[2]) & ~mask_r[2]) != 8'h00) |=> st_r == hrf_pkg::ST_DISCARD)
		else $error("mismatching address accepted");
	AST_CHECK_OFF: assert property (
		!lim_hi_r[`HRF_LIMIT_ENABLE] |=> !evt_r[0][0] || $past(evt_r[0][0]))
		else $error("length event with check disabled");
	AST_COUNT_STEP: assert property (
		fifo_wr.valid |=> cnt_r == $past(cnt_r) + 17'h00001)
		else $error("written byte not counted");
	AST_LIMIT_VALUE: assert property (
		ev_length_exceeded_event |-> cnt_r + 17'h00002 > ({6'h00, lim_hi_r[2:0], lim_lo_r} + 17'h00001) * 32)
		else $error("length event below limit");
	AST_LENGTH_EXCEEDED_EVENT_ORDER: assert property (
		s_over_byte |=> s_abort_status ##0 evt_r[0][0])
		else $error("over-length frame not ended as aborted");
	AST_STATUS_LAST: assert property (
		fifo_wr.last |-> fifo_wr.valid && ev_rme && fifo_wr.data[4] == abort_r ##1
		st_r == hrf_pkg::ST_IDLE && evt_r[0][2])
		else $error("status byte not last or no message end");
	AST_OVERFLOW: assert property (
		st_r == hrf_pkg::ST_DATA && rx.byte_valid && !rx.line_abort && !rx.frame_end &&
		!over && fifo_full && cnt_r != 17'h00000 |=> evt_r[0][7] && ovf_r)
		else $error("lost byte not flagged");
	AST_FIFO_OVF: assert property (
		st_r == hrf_pkg::ST_DATA && rx.byte_valid && !rx.line_abort && !rx.frame_end &&
		!over && fifo_full && cnt_r == 17'h00000 |=> evt_r[0][6] &&
		st_r == hrf_pkg::ST_DISCARD)
		else $error("dropped frame not flagged");
	AST_IRQ_MASKED: assert property (
		##1 irq |-> $past(|(evt_r[0] & ~emask_r[0]) | |(evt_r[1] & ~emask_r[1]) |
		|(evt_r[2] & ~emask_r[2])))
		else $error("interrupt from masked events");
	AST_READ_CLEAR: assert property (
		arvalid && arready && araddr == AW'({`HRF_IDX_EVT0, 2'h0}) && ev0 == 8'h00
		|=> evt_r[0] == 8'h00 && rdata_r == $past(evt_r[0]))
		else $error("event register not cleared by read");
endmodule // hrf_rx_filter
`default_nettype wire

// ---- tb/hrf_station.sv ----
`timescale 1ns/1ps
`default_nettype none
module hrf_station (
	// clock
	input  wire logic               aclk,
	// byte stream into the receiver
	output var hrf_pkg::hrf_rx_in_t rx
);
	logic [7:0] last_d;
	initial begin
		rx = '0;
		last_d = 8'h00;
	end
	// one cycle of the stream; idle data keeps toggling
	task automatic put(input logic s, v, e, input logic [7:0] d);
		rx <= '{start: s, byte_valid: v, data: d, frame_end: e,
			line_abort: 1'b0, crc_ok: e, valid_frame: e};
		last_d = d;
		@(posedge aclk);
	endtask
	// start flag, address (high first), data with gaps, end
	task automatic frame(input int n, input logic two, input logic [15:0] adr,
		input int gap);
		put(1'b0, 1'b0, 1'b0, ~last_d);
		put(1'b1, 1'b0, 1'b0, ~last_d);
		if (two) put(1'b0, 1'b1, 1'b0, adr[15:8]);
		if (two) put(1'b0, 1'b1, 1'b0, adr[7:0]);
		for (int i = 0; i < n; i++) begin
			put(1'b0, 1'b1, 1'b0, 8'($urandom));
			repeat (gap) put(1'b0, 1'b0, 1'b0, ~last_d);
		end
		put(1'b0, 1'b0, 1'b1, ~last_d);
		put(1'b0, 1'b0, 1'b0, ~last_d);
	endtask
endmodule // hrf_station
`default_nettype wire

// ---- tb/tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb;
	logic        aclk, aresetn, fifo_full, irq;
	logic        awvalid, awready, wvalid, wready, bvalid, bready;
	logic        arvalid, arready, rvalid, rready;
	logic [11:0] awaddr, araddr;
	logic [31:0] wdata, rdata, rd;
	logic [3:0]  wstrb;
	logic [2:0]  awprot, arprot;
	logic [1:0]  bresp, rresp;
	logic [7:0]  last_b, v, c, m, a;
	logic [7:0]  mdl [logic [7:0]];
	int          fail_count, samples_checked, n_wr, lim, ex;
	hrf_pkg::hrf_rx_in_t   rx;
	hrf_pkg::hrf_auto_in_t auto_ev;
	hrf_pkg::hrf_ext_ev_t  ext_ev;
	hrf_pkg::hrf_fifo_wr_t fifo_wr;
	hrf_rx_filter dut (.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid),
		.awready(awready), .awaddr(awaddr), .awprot(awprot), .wvalid(wvalid),
		.wready(wready), .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid),
		.bready(bready), .bresp(bresp), .arvalid(arvalid), .arready(arready),
		.araddr(araddr), .arprot(arprot), .rvalid(rvalid), .rready(rready),
		.rdata(rdata), .rresp(rresp), .rx(rx), .auto_ev(auto_ev),
		.ext_ev(ext_ev), .fifo_wr(fifo_wr), .fifo_full(fifo_full), .irq(irq));
	hrf_station stn (.aclk(aclk), .rx(rx));
	initial begin
		aclk = 1'b0;
		forever #25 aclk = ~aclk;
	end
	// count fifo writes, keep the status byte, data bytes pass unchanged
	always @(posedge aclk) begin
		if (fifo_wr.valid === 1'b1) begin
			n_wr++;
			if (fifo_wr.last === 1'b0) chk(fifo_wr.data, rx.data);
			if (fifo_wr.last === 1'b1) last_b = fifo_wr.data;
		end
	end
	// ----
	// bus tasks
	// ----
	task automatic chk(input logic [31:0] got, exp);
		samples_checked++;
		if (got !== exp) begin
			fail_count++;
			$display("unexpected at %0t: got %h, expected %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] idx, d);
		logic aw, w;
		aw = 1'b1;
		w = 1'b1;
		mdl[idx] = d;
		awaddr <= {2'b00, idx, 2'b00};
		wdata <= {24'h000000, d};
		{awvalid, wvalid, bready} <= 3'b111;
		while (aw || w) begin
			@(posedge aclk);
			if (awready) aw = 1'b0;
			if (wready) w = 1'b0;
			awvalid <= aw;
			wvalid <= w;
		end
		do @(posedge aclk); while (bvalid !== 1'b1);
		bready <= 1'b0;
		@(posedge aclk);
	endtask
	task automatic rchk(input logic [7:0] idx, exp, msk);
		araddr <= {2'b00, idx, 2'b00};
		{arvalid, rready} <= 2'b11;
		do @(posedge aclk); while (arready !== 1'b1);
		arvalid <= 1'b0;
		do @(posedge aclk); while (rvalid !== 1'b1);
		rready <= 1'b0;
		rd = rdata;
		chk(rd & {24'h000000, msk}, {24'h000000, exp});
		@(posedge aclk);
	endtask
	task automatic end_of_test();
		$display("compares %0d, mismatches %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	// ----
	// test sequence
	// ----
	initial begin
		void'($urandom(32'h7414));
		{aresetn, awvalid, wvalid, bready, arvalid, rready, fifo_full} = '0;
		{awaddr, araddr, wdata, awprot, arprot} = '0;
		{wstrb, auto_ev, ext_ev} = {4'hF, 14'h0000};
		{fail_count, samples_checked, n_wr} = '0;
		repeat (6) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		for (int i = 8'h44; i <= 8'h49; i++) begin
			rchk(i[7:0], 8'h00, 8'hFF);
			wr(i[7:0], 8'($urandom));
			rchk(i[7:0], mdl[i[7:0]], 8'hFF);
			wr(i[7:0], 8'h00);
		end
		rchk(8'h50, 8'h00, 8'hFF);
		rchk(8'h54, 8'hFF, 8'hFF);
		// address compare with per-bit masks, match then miss
		wr(8'h5C, 8'h6D);
		wr(8'h40, 8'h3C);
		c = 8'($urandom) | 8'h80;
		m = 8'($urandom) & 8'h7E;
		wr(8'h41, c);
		wr(8'h45, m);
		for (int k = 0; k < 2; k++) begin
			a = c ^ (m & 8'($urandom)) ^ k[7:0];
			n_wr = 0;
			stn.frame(6, 1'b1, {a, 8'h3C}, k);
			repeat (3) @(posedge aclk);
			chk(n_wr, k ? 0 : 7);
			rchk(8'h50, k ? 8'h00 : 8'h06, 8'h06);
		end
		// length limit off, on at 32, on at 64
		wr(8'h5C, 8'h61);
		for (int e = 0; e < 3; e++) begin
			wr(8'h48, {7'h00, e == 2});
			wr(8'h49, {e != 0, 7'h00});
			lim = ((e == 2) + 1) * 32;
			ex = (e != 0 && 41 > lim) ? lim : 41;
			n_wr = 0;
			stn.frame(40, 1'b0, 16'h0000, e);
			repeat (3) @(posedge aclk);
			chk(n_wr, ex);
			chk(last_b[4], ex != 41);
			rchk(8'h50, {4'h0, ex == 41, 2'b10, ex != 41}, 8'h0D);
			rchk(8'h50, 8'h00, 8'hFF);
		end
		// two bytes lost mid-frame, then a whole frame lost
		wr(8'h5C, 8'h71);
		n_wr = 0;
		fork
			stn.frame(10, 1'b0, 16'h0000, 0);
			begin
				repeat (6) @(posedge aclk);
				fifo_full <= 1'b1;
				repeat (2) @(posedge aclk);
				fifo_full <= 1'b0;
			end
		join
		repeat (3) @(posedge aclk);
		chk(n_wr, 9);
		chk(last_b[6], 1'b1);
		rchk(8'h5B, 8'h10, 8'h10);
		rchk(8'h50, 8'h84, 8'hC4);
		fifo_full <= 1'b1;
		n_wr = 0;
		stn.frame(3, 1'b0, 16'h0000, 0);
		fifo_full <= 1'b0;
		repeat (3) @(posedge aclk);
		chk(n_wr, 0);
		rchk(8'h50, 8'h40, 8'h40);
		// automode checks and collected link events
		wr(8'h5C, 8'h63);
		v = 8'($urandom) & 8'hFE;
		auto_ev <= 4'b1001;
		ext_ev <= {v, 2'b11};
		@(posedge aclk);
		{auto_ev, ext_ev} <= '0;
		repeat (2) @(posedge aclk);
		rchk(8'h50, 8'h30, 8'h30);
		rchk(8'h5D, 8'h01, 8'h01);
		rchk(8'h51, v, 8'hFF);
		rchk(8'h51, 8'h00, 8'hFF);
		rchk(8'h52, 8'h03, 8'hFF);
		// only the unmasked message end drives irq
		wr(8'h54, 8'hFB);
		stn.frame(2, 1'b0, 16'h0000, 0);
		repeat (4) @(posedge aclk);
		chk(irq, 1'b1);
		rchk(8'h50, 8'h04, 8'h04);
		repeat (2) @(posedge aclk);
		chk(irq, 1'b0);
		end_of_test();
	end
	initial begin
		repeat (4000) @(posedge aclk);
		fail_count++;
		end_of_test();
	end
endmodule // tb
`default_nettype wire
